/* File: logic/gso_pkg.sv */
package gso_pkg;
    localparam int          NUM_FIBRE       = 4;
    localparam longint      CLK_HZ          = 200000000;
    // times in their own units
    localparam longint      INIT_TIME_MIN   = 15;
    localparam longint      PULSE_ON_MS     = 200;
    localparam longint      PULSE_OFF_MS    = 800;
    localparam longint      TEST_FREQ_HZ    = 625000;
    localparam int          TEST_DUTY_PCT   = 50;
    localparam int          MIN_SATS        = 4;
    // derived cycle counts
    localparam longint      INIT_CYCLES     = INIT_TIME_MIN * 60 * CLK_HZ;
    localparam longint      PULSE_ON_CYCLES = PULSE_ON_MS * (CLK_HZ / 1000);
    localparam longint      SECOND_CYCLES   =
        (PULSE_ON_MS + PULSE_OFF_MS) * (CLK_HZ / 1000);
    localparam int          TEST_HALF_CYCLES =
        int'(CLK_HZ * TEST_DUTY_PCT / (100 * TEST_FREQ_HZ));
    localparam int          FLASH_HALF_CYCLES = 50000000;
    // register map
    localparam logic [7:0]  ADDR_FIBRE_MODE = 8'h00;
    localparam logic [7:0]  ADDR_TC_MODE    = 8'h04;
    localparam logic [7:0]  ADDR_STATUS     = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h10;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    localparam logic [11:0] FIBRE_MODE_RST  = 12'h000;
    localparam logic [3:0]  TC_MODE_RST     = 4'h0;
    localparam logic [3:0]  IRQ_MASK_RST    = 4'h0;
    // irq bit positions
    localparam int          IRQ_SYNC_ON     = 0;
    localparam int          IRQ_SYNC_OFF    = 1;
    localparam int          IRQ_ANT_FAIL    = 2;
    localparam int          IRQ_INIT_DONE   = 3;

    typedef enum logic [2:0] {
        GSO_OFF      = 3'b000,
        GSO_RELAY    = 3'b001,
        GSO_MU_AUTO  = 3'b010,
        GSO_MU_GPS   = 3'b011,
        GSO_TEST     = 3'b100
    } gso_fibre_mode_e;

    typedef enum logic [1:0] {
        GSO_TC_OFF   = 2'b00,
        GSO_TC_MOD   = 2'b01,
        GSO_TC_UNMOD = 2'b10
    } gso_tc_mode_e;

    typedef enum logic [1:0] {
        GSO_INIT     = 2'b00,
        GSO_HOLD     = 2'b01,
        GSO_SYNC     = 2'b10
    } gso_state_e;
endpackage

/* File: logic/gso_sync_out.sv */
`timescale 1ns/1ps
`default_nettype none
module gso_sync_out
    import gso_pkg::*;
#(
    parameter longint INIT_CYCLES_P   = gso_pkg::INIT_CYCLES,
    parameter longint SECOND_CYCLES_P = gso_pkg::SECOND_CYCLES,
    parameter longint PULSE_CYCLES_P  = gso_pkg::PULSE_ON_CYCLES,
    parameter int     FLASH_CYCLES_P  = gso_pkg::FLASH_HALF_CYCLES
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [31:0]                   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [31:0]                   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          pps_tick,
    input  wire logic [4:0]                    sat_count,
    input  wire logic                          antenna_ok,
    input  wire logic                          self_test_ok,
    input  wire logic                          timecode_bit,
    input  wire logic                          timecode_mod,
    output logic [gso_pkg::NUM_FIBRE-1:0]      fibre_tx,
    output logic                               coax_timecode_socket,
    output logic                               diff_timecode_socket,
    output logic                               unit_healthy_led,
    output logic                               antenna_fail_led,
    output logic                               sync_led,
    output logic                               test_mode_led,
    output logic                               irq
);
    import gso_pkg::*;

    function automatic gso_fibre_mode_e mode_of(input logic [11:0] f,
                                                input int i);
        return gso_fibre_mode_e'(f[3*i +: 3]);
    endfunction

    // registers
    logic [11:0]   fibre_mode_reg;
    logic [3:0]    tc_mode_reg;
    logic [3:0]    irq_stat_reg;
    logic [3:0]    irq_mask_reg;
    gso_state_e    state_reg;
    logic [37:0]   init_cnt_reg;
    logic [31:0]   sec_cnt_reg;
    logic [7:0]    sq_cnt_reg;
    logic          sq_reg;
    logic [31:0]   flash_cnt_reg;
    logic          flash_reg;
    logic [NUM_FIBRE-1:0] fibre_tx_reg;
    logic          coax_reg;
    logic          diff_reg;
    logic          healthy_reg;
    logic          ant_reg;
    logic          sync_reg;
    logic          test_led_reg;
    logic          emit_prev_reg;
    logic          ant_prev_reg;
    logic          init_prev_reg;
    logic          aw_hold_reg;
    logic          w_hold_reg;
    logic [7:0]    awaddr_reg;
    logic [31:0]   wdata_reg;
    logic [3:0]    wstrb_reg;
    logic          bvalid_reg;
    logic [1:0]    bresp_reg;
    logic          rvalid_reg;
    logic [1:0]    rresp_reg;
    logic [31:0]   rdata_reg;

    // axi4-lite decode
    wire aw_take   = s_axi_awvalid && !aw_hold_reg && !bvalid_reg;
    wire w_take    = s_axi_wvalid && !w_hold_reg && !bvalid_reg;
    wire aw_have   = aw_hold_reg || aw_take;
    wire w_have    = w_hold_reg || w_take;
    wire wr_fire   = aw_have && w_have && !bvalid_reg;
    wire [7:0]  wa = aw_hold_reg ? awaddr_reg : s_axi_awaddr[7:0];
    wire [31:0] wd = w_hold_reg ? wdata_reg : s_axi_wdata;
    wire [3:0]  ws = w_hold_reg ? wstrb_reg : s_axi_wstrb;
    wire wr_hi_ok  = (aw_hold_reg ? 1'b1 : (s_axi_awaddr[31:8] == 24'h0));
    wire wr_mode   = wr_fire && wr_hi_ok && wa == ADDR_FIBRE_MODE;
    wire wr_tc     = wr_fire && wr_hi_ok && wa == ADDR_TC_MODE;
    wire wr_stat   = wr_fire && wr_hi_ok && wa == ADDR_IRQ_STAT && ws[0];
    wire wr_mask   = wr_fire && wr_hi_ok && wa == ADDR_IRQ_MASK && ws[0];
    wire wr_known  = wr_hi_ok && (wa == ADDR_FIBRE_MODE || wa == ADDR_TC_MODE
                     || wa == ADDR_STATUS || wa == ADDR_IRQ_STAT
                     || wa == ADDR_IRQ_MASK);
    wire rd_fire   = s_axi_arvalid && !rvalid_reg;
    wire rd_hi_ok  = s_axi_araddr[31:8] == 24'h0;
    wire [7:0] ra  = s_axi_araddr[7:0];

    assign s_axi_awready = aw_take;
    assign s_axi_wready  = w_take;
    assign s_axi_arready = rd_fire;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;

    // status and mode decode
    wire sats_low   = sat_count < 5'(MIN_SATS);
    wire sats_high  = sat_count > 5'(MIN_SATS);
    wire init_done  = init_cnt_reg == 38'(INIT_CYCLES_P);
    wire emitting   = state_reg == GSO_SYNC;
    wire sec_end    = sec_cnt_reg == 32'(SECOND_CYCLES_P - 1);
    wire pulse_on   = sec_cnt_reg < 32'(PULSE_CYCLES_P);
    wire sq_end     = sq_cnt_reg == 8'(TEST_HALF_CYCLES - 1);
    wire flash_end  = flash_cnt_reg == 32'(FLASH_CYCLES_P - 1);

    logic [NUM_FIBRE-1:0] fibre_next;
    logic                 any_test;
    always_comb begin
        fibre_next = '0;
        any_test   = 1'b0;
        for (int i = 0; i < NUM_FIBRE; i++) begin
            unique case (mode_of(fibre_mode_reg, i))
                GSO_OFF:  fibre_next[i] = 1'b0;
                GSO_TEST: begin
                    fibre_next[i] = sq_reg;
                    any_test      = 1'b1;
                end
                GSO_RELAY, GSO_MU_AUTO, GSO_MU_GPS:
                    fibre_next[i] = emitting && pulse_on;
                default:  fibre_next[i] = 1'b0;
            endcase
        end
    end

    wire coax_next = !init_done ? 1'b0 :
        (tc_mode_reg[1:0] == GSO_TC_UNMOD) ? timecode_bit :
        (tc_mode_reg[1:0] == GSO_TC_MOD)   ? timecode_mod : 1'b0;
    wire diff_next = init_done &&
        (tc_mode_reg[3:2] == GSO_TC_UNMOD) && timecode_bit;

    wire [3:0] irq_ev;
    assign irq_ev[IRQ_SYNC_ON]   = emitting && !emit_prev_reg;
    assign irq_ev[IRQ_SYNC_OFF]  = !emitting && emit_prev_reg;
    assign irq_ev[IRQ_ANT_FAIL]  = !antenna_ok && ant_prev_reg;
    assign irq_ev[IRQ_INIT_DONE] = init_done && !init_prev_reg;
    wire [3:0] stat_clr = wr_stat ? wd[3:0] : 4'h0;
    assign irq = |(irq_stat_reg & irq_mask_reg);

    wire [31:0] status_word = {26'h0, irq_stat_reg != 4'h0, any_test,
                               init_done, !antenna_ok, emitting,
                               self_test_ok};

    // sync state machine
    gso_state_e state_next;
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            GSO_INIT: if (init_done) state_next = GSO_HOLD;
            GSO_HOLD: if (sats_high && antenna_ok)
                state_next = GSO_SYNC;
            GSO_SYNC: if (sats_low || !antenna_ok)
                state_next = GSO_HOLD;
            default:  state_next = GSO_INIT;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg     <= GSO_INIT;
            init_cnt_reg  <= 38'h0;
            emit_prev_reg <= 1'b0;
            ant_prev_reg  <= 1'b1;
            init_prev_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            if (!init_done)
                init_cnt_reg <= init_cnt_reg + 38'h1;
            emit_prev_reg <= emitting;
            ant_prev_reg  <= antenna_ok;
            init_prev_reg <= init_done;
        end
    end

    // seconds timebase, restarted by the pps tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sec_cnt_reg <= 32'h0;
        end else if (pps_tick || sec_end) begin
            sec_cnt_reg <= 32'h0;
        end else begin
            sec_cnt_reg <= sec_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sq_cnt_reg    <= 8'h0;
            sq_reg        <= 1'b0;
            flash_cnt_reg <= 32'h0;
            flash_reg     <= 1'b0;
        end else begin
            sq_cnt_reg    <= sq_end ? 8'h0 : sq_cnt_reg + 8'h1;
            if (sq_end)
                sq_reg <= !sq_reg;
            flash_cnt_reg <= flash_end ? 32'h0 : flash_cnt_reg + 32'h1;
            if (flash_end)
                flash_reg <= !flash_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fibre_tx_reg <= '0;
            coax_reg     <= 1'b0;
            diff_reg     <= 1'b0;
            healthy_reg  <= 1'b0;
            ant_reg      <= 1'b0;
            sync_reg     <= 1'b0;
            test_led_reg <= 1'b0;
        end else begin
            fibre_tx_reg <= init_done ? fibre_next : '0;
            coax_reg     <= coax_next;
            diff_reg     <= diff_next;
            healthy_reg  <= self_test_ok;
            ant_reg      <= !antenna_ok;
            sync_reg     <= emitting;
            test_led_reg <= any_test && flash_reg;
        end
    end

    assign fibre_tx             = fibre_tx_reg;
    assign coax_timecode_socket = coax_reg;
    assign diff_timecode_socket = diff_reg;
    assign unit_healthy_led     = healthy_reg;
    assign antenna_fail_led     = ant_reg;
    assign sync_led             = sync_reg;
    assign test_mode_led        = test_led_reg;

    // register file and bus slave
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fibre_mode_reg <= FIBRE_MODE_RST;
            tc_mode_reg    <= TC_MODE_RST;
            irq_mask_reg   <= IRQ_MASK_RST;
            irq_stat_reg   <= 4'h0;
            aw_hold_reg    <= 1'b0;
            w_hold_reg     <= 1'b0;
            awaddr_reg     <= 8'h0;
            wdata_reg      <= 32'h0;
            wstrb_reg      <= 4'h0;
            bvalid_reg     <= 1'b0;
            bresp_reg      <= RESP_OKAY;
            rvalid_reg     <= 1'b0;
            rresp_reg      <= RESP_OKAY;
            rdata_reg      <= 32'h0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~stat_clr) | irq_ev;
            if (wr_mode) begin
                if (ws[0]) fibre_mode_reg[7:0]  <= wd[7:0];
                if (ws[1]) fibre_mode_reg[11:8] <= wd[11:8];
            end
            if (wr_tc && ws[0]) tc_mode_reg  <= wd[3:0];
            if (wr_mask)        irq_mask_reg <= wd[3:0];
            if (aw_take && !wr_fire) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr[31:8] == 24'h0 ?
                               s_axi_awaddr[7:0] : 8'hFF;
            end
            if (w_take && !wr_fire) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= RESP_OKAY;
                if (!rd_hi_ok) begin
                    rdata_reg <= 32'h0;
                    rresp_reg <= RESP_SLVERR;
                end else begin
                    unique case (ra)
                        ADDR_FIBRE_MODE: rdata_reg <= {20'h0, fibre_mode_reg};
                        ADDR_TC_MODE:    rdata_reg <= {28'h0, tc_mode_reg};
                        ADDR_STATUS:     rdata_reg <= status_word;
                        ADDR_IRQ_STAT:   rdata_reg <= {28'h0, irq_stat_reg};
                        ADDR_IRQ_MASK:   rdata_reg <= {28'h0, irq_mask_reg};
                        default: begin
                            rdata_reg <= 32'h0;
                            rresp_reg <= RESP_SLVERR;
                        end
                    endcase
                end
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // checks
    a_dark_before_init: assert property (@(posedge aclk) disable iff (!aresetn)
        !init_done |=> (fibre_tx == '0 && !sync_led))
        else $error("output active before initialisation");
    a_sync_drop_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (emitting && sats_low) |=> !emitting)
        else $error("sync kept with too few satellites");
    a_sync_led_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        emitting |=> sync_led)
        else $error("sync indicator not lit");
    a_healthy_led: assert property (@(posedge aclk) disable iff (!aresetn)
        self_test_ok |=> unit_healthy_led)
        else $error("healthy indicator dark");
    a_antenna_led: assert property (@(posedge aclk) disable iff (!aresetn)
        !antenna_ok |=> antenna_fail_led)
        else $error("antenna fail not shown");
    a_no_reinit: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == GSO_HOLD && sats_high && antenna_ok)
        |=> state_reg == GSO_SYNC)
        else $error("resume waited after reconnect");
    a_pulse_window: assert property (@(posedge aclk) disable iff (!aresetn)
        (init_done && emitting && !pulse_on &&
         mode_of(fibre_mode_reg, 0) == GSO_RELAY)
        |=> !fibre_tx[0])
        else $error("light during off period");
    a_test_square: assert property (@(posedge aclk) disable iff (!aresetn)
        (sq_end && $stable(sq_reg)) |=> sq_reg != $past(sq_reg))
        else $error("test square wave stalled");
    a_off_dark: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode_of(fibre_mode_reg, 1) == GSO_OFF) |=> !fibre_tx[1])
        else $error("off output emits light");
    a_test_led_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !any_test |=> !test_mode_led)
        else $error("test indicator without test mode");
endmodule
`default_nettype wire

/* File: testbench/gso_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gso_rx_model #(
    parameter int PULSE_P  = 20,
    parameter int SECOND_P = 100
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       light,
    input  wire logic [6:0] manual_year,
    output logic            locked,
    output logic [6:0]      year
);
    logic light_d;
    int   run_len;
    int   on_len;
    assign year = manual_year;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            light_d <= 1'b0;
            run_len <= 0;
            on_len <= 0;
            locked <= 1'b0;
        end else begin
            light_d <= light;
            run_len <= (light != light_d) ? 1 : run_len + 1;
            if (!light && light_d)
                on_len <= run_len;
            // only the on/off framing counts, a square wave is loss
            if (light && !light_d)
                locked <= on_len == PULSE_P &&
                          run_len == SECOND_P - PULSE_P;
            else if (run_len > 2 * SECOND_P)
                locked <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import gso_pkg::*;
    localparam int SEC = 100;
    localparam int PW  = 20;
    logic        aclk, aresetn, pps, ant_ok, tc_bit, tc_mod;
    logic [4:0]  sats;
    logic [31:0] awaddr, wdata, araddr, rdata, d;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, coax, diff, hl, al;
    logic        sl, tl, irq, rlock, tlock, st_ok;
    logic [1:0]  bresp, rresp, r;
    logic [3:0]  fx, strb;
    logic [6:0]  yr;
    int          fail_count, tests_run, pc, w, n;
    gso_sync_out #(.INIT_CYCLES_P(50), .SECOND_CYCLES_P(SEC),
        .PULSE_CYCLES_P(PW), .FLASH_CYCLES_P(4)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pps_tick(pps), .sat_count(sats),
        .antenna_ok(ant_ok), .self_test_ok(st_ok), .timecode_bit(tc_bit),
        .timecode_mod(tc_mod), .fibre_tx(fx), .coax_timecode_socket(coax),
        .diff_timecode_socket(diff), .unit_healthy_led(hl),
        .antenna_fail_led(al), .sync_led(sl), .test_mode_led(tl),
        .irq(irq));
    gso_rx_model #(.PULSE_P(PW), .SECOND_P(SEC)) rx_u (.aclk(aclk),
        .aresetn(aresetn), .light(fx[0]), .manual_year(7'h19),
        .locked(rlock), .year(yr));
    gso_rx_model #(.PULSE_P(PW), .SECOND_P(SEC)) rx_t (.aclk(aclk),
        .aresetn(aresetn), .light(fx[3]), .manual_year(7'h19),
        .locked(tlock), .year());
    initial begin
        aclk = 0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        pc <= (pc == SEC - 1) ? 0 : pc + 1;
        pps <= pc == SEC - 1;
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, wd;
        aw = 0;
        wd = 0;
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= v;
        strb <= 4'hF;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw && wd)) begin
            @(negedge aclk);
            aw = aw | (awvalid & awready);
            wd = wd | (wvalid & wready);
            @(posedge aclk);
            if (aw) awvalid <= 0;
            if (wd) wvalid <= 0;
        end
        @(negedge aclk);
        while (bvalid !== 1) @(negedge aclk);
        r = bresp;
        @(posedge aclk);
        bready <= 0;
        chk("bresp", r, RESP_OKAY);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1;
        rready <= 1;
        @(negedge aclk);
        while (!arready) @(negedge aclk);
        @(posedge aclk);
        arvalid <= 0;
        @(negedge aclk);
        while (rvalid !== 1) @(negedge aclk);
        d = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 0;
        chk("rdata", d & (a == 8'h08 ? 32'h1F : 32'hFFF), e);
    endtask
    task automatic ws(ref logic s, input logic v, input string nm);
        n = 0;
        @(negedge aclk);
        while (s !== v && n < 300) begin
            @(negedge aclk);
            n++;
        end
        chk(nm, s, v);
    endtask
    task automatic width(input int i, input logic v);
        w = 0;
        @(negedge aclk);
        while (fx[i] === v) @(negedge aclk);
        while (fx[i] !== v) @(negedge aclk);
        while (fx[i] === v && w < 999) begin
            @(negedge aclk);
            w++;
        end
    endtask
    task automatic t_init();
        chk("healthy", hl, 1);
        rd(8'h00, {20'h0, FIBRE_MODE_RST});
        rd(8'h10, {28'h0, IRQ_MASK_RST});
        rd(8'h24, 0);
        chk("unmapped", r, RESP_SLVERR);
        wr(8'h00, 32'h811);
        wr(8'h04, 32'hA);
        rd(8'h00, 32'h811);
        n = 0;
        repeat (10) @(negedge aclk) n += (fx != 0) | coax | diff | sl;
        chk("init_quiet", n, 0);
        ws(sl, 1, "sync_on");
    endtask
    task automatic t_pulse();
        width(0, 1);
        chk("on_len", w, PW);
        width(0, 0);
        chk("off_len", w, SEC - PW);
        n = 0;
        repeat (SEC) @(negedge aclk) n += (fx[0] !== fx[1]) | fx[2];
        chk("aligned", n, 0);
        width(3, 1);
        chk("test_half", w, TEST_HALF_CYCLES);
        n = 0;
        repeat (40) @(negedge aclk) n += tl;
        chk("test_led", n > 8 && n < 32, 1);
        chk("rx_locks", {rlock, tlock, yr}, {2'b10, 7'h19});
        rd(8'h08, 32'h1B);
    endtask
    task automatic t_sats();
        wr(8'h0C, 32'hF);
        chk("irq_masked", irq, 0);
        sats <= 5'd3;
        ws(sl, 0, "sync_drop");
        @(posedge aclk);
        sats <= 5'd4;
        n = 0;
        repeat (2 * SEC) @(negedge aclk) n += fx[0] | sl;
        chk("at_four", n, 0);
        rd(8'h0C, 32'h2);
        wr(8'h10, 32'h2);
        chk("irq_on", irq, 1);
        wr(8'h0C, 32'h2);
        chk("irq_clr", irq, 0);
        sats <= 5'd5;
        ws(sl, 1, "sync_back");
    endtask
    task automatic t_ant_tc();
        @(posedge aclk);
        st_ok <= 0;
        ant_ok <= 0;
        ws(al, 1, "ant_fail");
        ws(sl, 0, "ant_sync");
        chk("unhealthy", hl, 0);
        @(posedge aclk);
        st_ok <= 1;
        ant_ok <= 1;
        repeat (20) @(posedge aclk);
        chk("no_reinit", sl, 1);
        chk("healthy_back", hl, 1);
        wr(8'h00, 32'h819);
        width(1, 1);
        chk("gps_mode_on", w, PW);
        for (int k = 0; k < 4; k++) begin
            if (k == 2) wr(8'h04, 32'h1);
            @(posedge aclk);
            tc_bit <= k[0];
            tc_mod <= k[1];
            repeat (2) @(negedge aclk);
            d = k < 2 ? {2{k[0]}} : {k[1], 1'b0};
            chk("tc", {coax, diff}, d);
        end
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 0;
        {pps, tc_mod, awaddr, wdata, araddr, fail_count, tests_run, pc} = 0;
        {st_ok, ant_ok, tc_bit, sats, strb} = {3'b111, 5'd8, 4'h0};
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        t_init();
        t_pulse();
        t_sats();
        t_ant_tc();
        close_out();
    end
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
endmodule
`default_nettype wire
